// ==== include/stc_pkg.sv ====
// constants and types shared by the stepper translator control block
package stc_pkg;
    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WAKE_MAX_US   = 40;
    // longest time: round down to whole cycles
    localparam int unsigned WAKE_MAX_CYC  = (WAKE_MAX_US * 1000) / CLK_PERIOD_NS;
    // pin synchroniser, state change and output register eat these cycles
    localparam int unsigned SYNC_LAT_CYC  = 4;
    localparam int unsigned WAKE_WAIT_CYC = WAKE_MAX_CYC - SYNC_LAT_CYC;
    localparam int unsigned WAKE_CNT_W    = 12;

    // ==========================================================
    // electrical angle in 1/16-step units, 64 per electrical period
    localparam int unsigned ANGLE_W     = 6;
    localparam logic [5:0]  INIT_ANGLE  = 6'h08;
    localparam logic [5:0]  QUARTER_OFS = 6'h10;
    localparam logic [5:0]  STEP_FULL   = 6'h10;
    localparam logic [5:0]  STEP_HALF   = 6'h08;
    localparam logic [5:0]  STEP_QUART  = 6'h04;
    localparam logic [5:0]  STEP_EIGHTH = 6'h02;
    localparam logic [5:0]  STEP_SIXT   = 6'h01;

    // ==========================================================
    // pin input positions in the synchroniser bank
    localparam int unsigned IN_STEP  = 0;
    localparam int unsigned IN_OE    = 1;
    localparam int unsigned IN_STBY  = 2;
    localparam int unsigned IN_DIR   = 3;
    localparam int unsigned IN_SEL0  = 4;
    localparam int unsigned IN_SEL1  = 5;
    localparam int unsigned IN_COUNT = 6;

    // ==========================================================
    // decay level thresholds in millivolts
    localparam int unsigned LEVEL_W      = 12;
    localparam logic [11:0] SLOW_MAX_MV  = 12'h12c;
    localparam logic [11:0] MIX_MIN_MV   = 12'h190;
    localparam logic [11:0] MIX_MAX_MV   = 12'h3e8;
    localparam logic [11:0] FAST_MIN_MV  = 12'h5dc;

    // ==========================================================
    // current reference scaling
    localparam logic [11:0] VREF_DIV     = 12'h005;
    localparam logic [19:0] FULL_GAIN    = 20'h000b5;
    localparam int unsigned FULL_GAIN_SH = 7;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        ST_STANDBY = 3'h1,
        ST_WAKE    = 3'h2,
        ST_RUN     = 3'h4
    } stc_state_type;

    typedef enum logic [5:0] {
        MODE_FULL      = 6'h01,
        MODE_HALF_A    = 6'h02,
        MODE_HALF_B    = 6'h04,
        MODE_QUARTER   = 6'h08,
        MODE_EIGHTH    = 6'h10,
        MODE_SIXTEENTH = 6'h20
    } stc_mode_type;

    typedef enum logic [2:0] {
        DECAY_SLOW = 3'h1,
        DECAY_MIX  = 3'h2,
        DECAY_FAST = 3'h4
    } stc_decay_type;
endpackage

// ==== logic/stc_sine_rom.sv ====
// two-port sine table giving the phase current for an electrical angle
`timescale 1ns/1ns
module stc_sine_rom (
    input  wire logic              clk_i,     // system clock
    input  wire logic              rst_n_i,   // synchronised reset, active low
    input  wire logic [5:0]        addr_a_i,  // angle for channel one
    input  wire logic [5:0]        addr_b_i,  // angle for channel two
    output logic signed [7:0]      data_a_o,  // registered current, channel one
    output logic signed [7:0]      data_b_o   // registered current, channel two
);
    // ==========================================================
    // quarter-wave table, mirrored and negated per quadrant
    function automatic logic [7:0] quarter(input logic [4:0] k);
        logic [7:0] v;
        v = 8'h00;
        case (k)
            5'h00: v = 8'h00;
            5'h01: v = 8'h0c;
            5'h02: v = 8'h19;
            5'h03: v = 8'h25;
            5'h04: v = 8'h31;
            5'h05: v = 8'h3c;
            5'h06: v = 8'h47;
            5'h07: v = 8'h51;
            5'h08: v = 8'h5a;
            5'h09: v = 8'h62;
            5'h0a: v = 8'h6a;
            5'h0b: v = 8'h70;
            5'h0c: v = 8'h75;
            5'h0d: v = 8'h7a;
            5'h0e: v = 8'h7d;
            5'h0f: v = 8'h7e;
            default: v = 8'h7f;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] sine(input logic [5:0] a);
        logic [4:0] k;
        logic [4:0] km;
        logic [7:0] m;
        k  = {1'b0, a[3:0]};
        km = 5'h10 - k;
        m  = a[4] ? quarter(km) : quarter(k);
        return a[5] ? 8'(-m) : m;
    endfunction

    logic signed [7:0] nxt_a;
    logic signed [7:0] nxt_b;

    always_comb begin
        nxt_a = sine(addr_a_i);
        nxt_b = sine(addr_b_i);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_a_o <= 8'sh00;
            data_b_o <= 8'sh00;
        end else begin
            data_a_o <= nxt_a;
            data_b_o <= nxt_b;
        end
    end
endmodule

// ==== logic/stc_translator.sv ====
// stepper translator: step counting, enable, standby, mode, decay and limit
//
// Behaviour
// - with output enable low the bridge is off and the angle is kept.
// - with output enable low step pulses do not move the angle but still set the applied direction.
// - a mode change made while output enable is low takes effect when it returns high.
// - with standby low the bridge is off and the translator is held at its reset angle.
// - after standby rises the bridge becomes active within 40 microseconds.
// - right after a translator reset the angle is 45 degrees in every mode.
// - direction low makes channel two lag channel one by 90 degrees, high makes it lead.
// - a direction change takes effect at the next step rising edge, not before.
// - the two select inputs choose the excitation mode, per variant.
// - an unconnected control input reads as low.
// - the decay level selects slow, mixed or fast decay by its voltage band.
// - the current reference is divided by five, and by 0.7071 in fine full-step mode.
// - each step rising edge while enabled and running snaps the angle down to the grid of the selected mode, then moves it by one step.
`timescale 1ns/1ns
module stc_translator #(
    parameter bit         FINE_VARIANT    = 1'b0,  // 0: four-mode part, 1: fine part
    parameter bit         FINE_HAS_EIGHTH = 1'b1,  // fine part: code 10 is eighth step
    parameter logic [5:0] INPUT_CONNECTED = 6'h3f  // one bit per control pin
) (
    input  wire logic         sys_clk_i,           // 100 MHz clock
    input  wire logic         reset_n_i,           // async reset, active low
    input  wire logic         step_pulse_i,        // step pin
    input  wire logic         output_enable_i,     // output enable pin
    input  wire logic         standby_control_i,   // standby pin, low = standby
    input  wire logic         direction_select_i,  // direction pin
    input  wire logic         excitation_sel0_i,   // mode select pin 0
    input  wire logic         excitation_sel1_i,   // mode select pin 1
    input  wire logic [11:0]  decay_select_level_i,// decay level, millivolts
    input  wire logic [11:0]  vref_level_i,        // current reference, millivolts
    output logic              bridge_on_o,         // high: bridge may conduct
    output logic              standby_o,           // high: in standby
    output logic [5:0]        elec_angle_o,        // electrical angle, 1/16 steps
    output logic [5:0]        active_mode_o,       // applied mode, one-hot
    output logic              dir_applied_o,       // direction in use
    output logic [2:0]        decay_mode_o,        // decay mode, one-hot
    output logic [11:0]       current_limit_o,     // sense threshold, millivolts
    output logic signed [7:0] ch1_current_o,       // channel one current target
    output logic signed [7:0] ch2_current_o        // channel two current target
);
    // ==========================================================
    // elaboration checks
    if (stc_pkg::WAKE_MAX_CYC <= stc_pkg::SYNC_LAT_CYC) begin : g_bad_wake
        $error("wake delay shorter than the pin latency");
    end
    if (stc_pkg::WAKE_WAIT_CYC >= (1 << stc_pkg::WAKE_CNT_W)) begin : g_bad_cnt
        $error("wake counter too narrow");
    end

    // ==========================================================
    // reset release
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_ff);

    // ==========================================================
    // pin synchronisers
    logic [5:0] pin_raw;
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;

    assign pin_raw = {excitation_sel1_i, excitation_sel0_i, direction_select_i,
                      standby_control_i, output_enable_i, step_pulse_i} & INPUT_CONNECTED;

    for (genvar i = 0; i < stc_pkg::IN_COUNT; i++) begin : g_sync
        always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
            if (!rst_n_ff) begin
                sync1_ff[i] <= 1'b0;
                sync2_ff[i] <= 1'b0;
            end else begin
                sync1_ff[i] <= pin_raw[i];
                sync2_ff[i] <= sync1_ff[i];
            end
        end
    end

    logic step_s;
    logic oe_s;
    logic stby_s;
    logic dir_s;
    assign step_s = sync2_ff[stc_pkg::IN_STEP];
    assign oe_s   = sync2_ff[stc_pkg::IN_OE];
    assign stby_s = sync2_ff[stc_pkg::IN_STBY];
    assign dir_s  = sync2_ff[stc_pkg::IN_DIR];

    // ==========================================================
    // translator state
    stc_pkg::stc_state_type  state_ff, nxt_state;
    stc_pkg::stc_mode_type   mode_ff, nxt_mode, mode_dec;
    stc_pkg::stc_decay_type  decay_ff, nxt_decay;
    logic [11:0] wake_cnt_ff, nxt_wake_cnt;
    logic [5:0]  angle_ff, nxt_angle;
    logic        step_prev_ff, nxt_step_prev;
    logic        dir_ff, nxt_dir;
    logic        bridge_on_ff, nxt_bridge_on;
    logic [11:0] limit_ff, nxt_limit;
    logic        step_rise;
    logic        adv_ok;
    logic [5:0]  step_sz;
    logic [5:0]  base;
    logic [11:0] lim_div;
    logic [19:0] lim_full;

    // rising edge of the synchronised step
    assign step_rise = step_s & ~step_prev_ff;
    // steps pass only while enabled and running
    assign adv_ok    = oe_s && (state_ff == stc_pkg::ST_RUN);

    always_comb begin
        case ({sync2_ff[stc_pkg::IN_SEL0], sync2_ff[stc_pkg::IN_SEL1]})
            2'b00: mode_dec = stc_pkg::MODE_FULL;
            2'b01: mode_dec = stc_pkg::MODE_HALF_A;
            2'b10: mode_dec = !FINE_VARIANT ? stc_pkg::MODE_HALF_B :
                              FINE_HAS_EIGHTH ? stc_pkg::MODE_EIGHTH : stc_pkg::MODE_QUARTER;
            default: mode_dec = FINE_VARIANT ? stc_pkg::MODE_SIXTEENTH : stc_pkg::MODE_QUARTER;
        endcase
        case (mode_ff)
            stc_pkg::MODE_FULL:      step_sz = stc_pkg::STEP_FULL;
            stc_pkg::MODE_HALF_A:    step_sz = stc_pkg::STEP_HALF;
            stc_pkg::MODE_HALF_B:    step_sz = stc_pkg::STEP_HALF;
            stc_pkg::MODE_QUARTER:   step_sz = stc_pkg::STEP_QUART;
            stc_pkg::MODE_EIGHTH:    step_sz = stc_pkg::STEP_EIGHTH;
            default:                 step_sz = stc_pkg::STEP_SIXT;
        endcase
        // snap to the grid of the current mode so a coarser mode lands on its own points
        base = (angle_ff - stc_pkg::INIT_ANGLE) & ~(step_sz - 6'h01);

        nxt_state     = state_ff;
        nxt_wake_cnt  = wake_cnt_ff;
        nxt_angle     = angle_ff;
        nxt_step_prev = step_s;
        nxt_dir       = dir_ff;
        // mode frozen while disabled, taken on when enable is high
        nxt_mode      = oe_s ? mode_dec : mode_ff;

        case (state_ff)
            stc_pkg::ST_STANDBY: begin
                nxt_wake_cnt = 12'h000;
                if (stby_s) begin
                    nxt_state = stc_pkg::ST_WAKE;
                end
            end
            stc_pkg::ST_WAKE: begin
                nxt_wake_cnt = wake_cnt_ff + 12'h001;
                if (wake_cnt_ff == 12'(stc_pkg::WAKE_WAIT_CYC - 1)) begin
                    nxt_state = stc_pkg::ST_RUN;
                end
            end
            stc_pkg::ST_RUN: begin
                nxt_wake_cnt = 12'h000;
            end
            default: nxt_state = stc_pkg::ST_STANDBY;
        endcase

        // direction taken only at a step edge
        if (step_rise) begin
            nxt_dir = dir_s;
        end
        // one step per edge; sign picks the lag or lead of channel two
        if (step_rise && adv_ok) begin
            nxt_angle = dir_s ? base + stc_pkg::INIT_ANGLE - step_sz
                              : base + stc_pkg::INIT_ANGLE + step_sz;
        end
        // standby holds translator reset; reset angle is 45 degrees
        if (!stby_s) begin
            nxt_state = stc_pkg::ST_STANDBY;
            nxt_angle = stc_pkg::INIT_ANGLE;
        end
        // bridge off while disabled or not yet running
        nxt_bridge_on = oe_s && stby_s && (state_ff == stc_pkg::ST_RUN);
    end

    // ==========================================================
    // decay band and current limit
    always_comb begin
        // band decode, the gaps between bands keep the last mode
        nxt_decay = decay_ff;
        if (decay_select_level_i <= stc_pkg::SLOW_MAX_MV) begin
            nxt_decay = stc_pkg::DECAY_SLOW;
        end else if (decay_select_level_i >= stc_pkg::MIX_MIN_MV &&
                     decay_select_level_i <= stc_pkg::MIX_MAX_MV) begin
            nxt_decay = stc_pkg::DECAY_MIX;
        end else if (decay_select_level_i >= stc_pkg::FAST_MIN_MV) begin
            nxt_decay = stc_pkg::DECAY_FAST;
        end
        // divide by five, fine full step gains 1/0.7071
        lim_div  = vref_level_i / stc_pkg::VREF_DIV;
        lim_full = (20'(lim_div) * stc_pkg::FULL_GAIN) >> stc_pkg::FULL_GAIN_SH;
        nxt_limit = (FINE_VARIANT && mode_ff == stc_pkg::MODE_FULL) ? lim_full[11:0] : lim_div;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff     <= stc_pkg::ST_STANDBY;
            mode_ff      <= stc_pkg::MODE_FULL;
            decay_ff     <= stc_pkg::DECAY_SLOW;
            wake_cnt_ff  <= 12'h000;
            angle_ff     <= stc_pkg::INIT_ANGLE;
            step_prev_ff <= 1'b0;
            dir_ff       <= 1'b0;
            bridge_on_ff <= 1'b0;
            limit_ff     <= 12'h000;
        end else begin
            state_ff     <= nxt_state;
            mode_ff      <= nxt_mode;
            decay_ff     <= nxt_decay;
            wake_cnt_ff  <= nxt_wake_cnt;
            angle_ff     <= nxt_angle;
            step_prev_ff <= nxt_step_prev;
            dir_ff       <= nxt_dir;
            bridge_on_ff <= nxt_bridge_on;
            limit_ff     <= nxt_limit;
        end
    end

    // ==========================================================
    // current targets: channel two sits a quarter period behind channel one
    stc_sine_rom u_rom (
        .clk_i    (sys_clk_i),
        .rst_n_i  (rst_n_ff),
        .addr_a_i (angle_ff),
        .addr_b_i (angle_ff - stc_pkg::QUARTER_OFS),
        .data_a_o (ch1_current_o),
        .data_b_o (ch2_current_o)
    );

    assign bridge_on_o     = bridge_on_ff;
    assign standby_o       = (state_ff == stc_pkg::ST_STANDBY);
    assign elec_angle_o    = angle_ff;
    assign active_mode_o   = mode_ff;
    assign dir_applied_o   = dir_ff;
    assign decay_mode_o    = decay_ff;
    assign current_limit_o = limit_ff;

    // ==========================================================
    // checks
    float_when_off_a: assert property (!oe_s [*2] |-> !bridge_on_ff)
        else $error("bridge on while output enable low");
    angle_hold_off_a: assert property ((!oe_s && stby_s) |=> $stable(angle_ff))
        else $error("angle moved while disabled");
    mode_hold_off_a: assert property ((!oe_s && $changed(mode_dec)) |=> $stable(mode_ff))
        else $error("mode changed while disabled");
    standby_reset_a: assert property (!stby_s [*2] |-> (angle_ff == stc_pkg::INIT_ANGLE
                                      && !bridge_on_ff && standby_o))
        else $error("standby did not reset translator");
    wake_bound_a: assert property ((state_ff == stc_pkg::ST_WAKE)
                                   |-> wake_cnt_ff < 12'(stc_pkg::WAKE_WAIT_CYC))
        else $error("wake delay exceeded");
    step_grid_a: assert property ((step_rise && adv_ok && stby_s && $stable(mode_ff))
        |=> angle_ff != $past(angle_ff) &&
            ((angle_ff - stc_pkg::INIT_ANGLE) & ($past(step_sz) - 6'h01)) == 6'h00)
        else $error("step did not land on mode grid");
    dir_at_edge_a: assert property (!step_rise |=> $stable(dir_applied_o))
        else $error("direction applied without step edge");
    decay_slow_a: assert property ((decay_select_level_i <= stc_pkg::SLOW_MAX_MV)
                                   |=> decay_ff == stc_pkg::DECAY_SLOW)
        else $error("slow decay not selected");
endmodule

// ==== dv/stc_step_source.sv ====
// step pulse source standing in for the outside controller
`timescale 1ns/1ns
module stc_step_source (
    input  wire logic clk_i,   // bench clock
    input  wire logic go_i,    // request one step pulse
    output logic      step_o,  // step pin drive
    output logic      busy_o   // pulse still in progress
);
    logic [2:0] cnt_ff = 3'h0;
    // ==========================================================
    // pulse shaping
    // high and low each last three cycles so the two-flop sync sees both
    always_ff @(posedge clk_i) begin
        if (go_i && (cnt_ff == 3'h0)) begin
            cnt_ff <= 3'h6;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
        end
    end
    assign step_o = (cnt_ff > 3'h3);
    assign busy_o = (cnt_ff != 3'h0);
endmodule

// ==== dv/tb_stc_translator.sv ====
// self-checking bench for the stepper translator control block
`timescale 1ns/1ns
module tb_stc_translator;
    logic               sys_clk_i = 1'b0;
    logic               reset_n_i = 1'b0;
    logic               go        = 1'b0;
    logic               busy;
    logic               step_pulse;
    logic               oe        = 1'b0;
    logic               stby      = 1'b0;
    logic               dir       = 1'b0;
    logic               sel0      = 1'b0;
    logic               sel1      = 1'b0;
    logic [11:0]        decay_lvl = 12'h000;
    logic [11:0]        vref      = 12'h000;
    logic               bridge_on;
    logic               standby;
    logic [5:0]         angle;
    logic [5:0]         mode;
    logic               dir_app;
    logic [2:0]         decay;
    logic [11:0]        limit;
    logic signed [7:0]  ch1;
    logic signed [7:0]  ch2;
    logic signed [7:0]  c1_init;
    int                 n_fail     = 0;
    int                 num_checks = 0;
    int                 cycles     = 0;
    logic [1:0]         codes [3]  = '{2'h1, 2'h2, 2'h3};
    logic [5:0]         modes [3]  = '{6'h02, 6'h04, 6'h08};
    logic [5:0]         steps [3]  = '{6'h08, 6'h08, 6'h04};
    logic [11:0]        lvls  [4]  = '{12'h12c, 12'h3e8, 12'h5dc, 12'h000};
    logic [2:0]         dks   [4]  = '{3'h1, 3'h2, 3'h4, 3'h1};
    logic [5:0]         exp_angle;
    logic [5:0]         f_angle;
    logic [5:0]         f_mode;
    logic               f_dir;
    logic [11:0]        f_limit;
    logic [5:0]         fmodes [3] = '{6'h02, 6'h10, 6'h20};

    always #5 sys_clk_i = ~sys_clk_i;

    stc_step_source src (
        .clk_i  (sys_clk_i),
        .go_i   (go),
        .step_o (step_pulse),
        .busy_o (busy)
    );

    stc_translator dut (
        .sys_clk_i            (sys_clk_i),
        .reset_n_i            (reset_n_i),
        .step_pulse_i         (step_pulse),
        .output_enable_i      (oe),
        .standby_control_i    (stby),
        .direction_select_i   (dir),
        .excitation_sel0_i    (sel0),
        .excitation_sel1_i    (sel1),
        .decay_select_level_i (decay_lvl),
        .vref_level_i         (vref),
        .bridge_on_o          (bridge_on),
        .standby_o            (standby),
        .elec_angle_o         (angle),
        .active_mode_o        (mode),
        .dir_applied_o        (dir_app),
        .decay_mode_o         (decay),
        .current_limit_o      (limit),
        .ch1_current_o        (ch1),
        .ch2_current_o        (ch2)
    );

    // fine variant with the direction pin left open, so it must read low
    stc_translator #(
        .FINE_VARIANT    (1'b1),
        .FINE_HAS_EIGHTH (1'b1),
        .INPUT_CONNECTED (6'h37)
    ) dut_fine (
        .sys_clk_i            (sys_clk_i),
        .reset_n_i            (reset_n_i),
        .step_pulse_i         (step_pulse),
        .output_enable_i      (oe),
        .standby_control_i    (stby),
        .direction_select_i   (dir),
        .excitation_sel0_i    (sel0),
        .excitation_sel1_i    (sel1),
        .decay_select_level_i (decay_lvl),
        .vref_level_i         (vref),
        .bridge_on_o          (),
        .standby_o            (),
        .elec_angle_o         (f_angle),
        .active_mode_o        (f_mode),
        .dir_applied_o        (f_dir),
        .decay_mode_o         (),
        .current_limit_o      (f_limit),
        .ch1_current_o        (),
        .ch2_current_o        ()
    );

    // ==========================================================
    // reporting
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // the run needs about 4200 cycles; a hang is cut off well beyond that
    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            close_out();
        end
    end

    // ==========================================================
    // pin access
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // one pulse of six cycles plus sync, angle and table latency
    task automatic step_once();
        @(posedge sys_clk_i);
        go <= 1'b1;
        @(posedge sys_clk_i);
        go <= 1'b0;
        wait_cyc(12);
    endtask

    task automatic set_code(input logic [1:0] code);
        @(posedge sys_clk_i);
        sel0 <= code[1];
        sel1 <= code[0];
        wait_cyc(6);
    endtask

    // ==========================================================
    // tests
    initial begin
        wait_cyc(8);
        reset_n_i <= 1'b1;
        wait_cyc(4);
        // steps arrive while enable and standby are held low
        step_once();
        step_once();
        chk(standby, 1'b1);
        chk(bridge_on, 1'b0);
        chk(angle, 6'h08);
        chk(mode, 6'h01);
        @(posedge sys_clk_i);
        stby <= 1'b1;
        @(posedge sys_clk_i);
        oe <= 1'b1;
        wait_cyc(3988);
        chk(bridge_on, 1'b0);
        // bridge turns on at the 4000th edge after the pin; look one edge later
        wait_cyc(12);
        chk(bridge_on, 1'b1);
        chk(standby, 1'b0);
        // 45 degrees on a full scale of 127
        c1_init = 8'sh5a;
        chk(ch1, c1_init);
        step_once();
        chk(angle, 6'h18);
        chk(ch2, c1_init);
        @(posedge sys_clk_i);
        dir <= 1'b1;
        wait_cyc(10);
        chk(dir_app, 1'b0);
        chk(angle, 6'h18);
        step_once();
        chk(dir_app, 1'b1);
        chk(angle, 6'h08);
        chk(f_dir, 1'b0);
        chk(f_angle, 6'h28);
        @(posedge sys_clk_i);
        dir <= 1'b0;
        step_once();
        exp_angle = 6'h18;
        for (int i = 0; i < 3; i++) begin
            set_code(codes[i]);
            chk(mode, modes[i]);
            chk(f_mode, fmodes[i]);
            step_once();
            exp_angle = exp_angle + steps[i];
            chk(angle, exp_angle);
        end
        @(posedge sys_clk_i);
        oe <= 1'b0;
        set_code(2'h0);
        chk(bridge_on, 1'b0);
        chk(mode, 6'h08);
        step_once();
        chk(angle, 6'h2c);
        @(posedge sys_clk_i);
        oe <= 1'b1;
        wait_cyc(6);
        chk(mode, 6'h01);
        chk(bridge_on, 1'b1);
        // off-grid angle snaps down to the full-step grid, then advances one step
        step_once();
        chk(angle, 6'h38);
        for (int i = 0; i < 4; i++) begin
            @(posedge sys_clk_i);
            decay_lvl <= lvls[i];
            wait_cyc(3);
            chk(decay, dks[i]);
        end
        @(posedge sys_clk_i);
        vref <= 12'h3e8;
        wait_cyc(3);
        chk(limit, 12'h0c8);
        chk(f_limit, 12'h11a);
        @(posedge sys_clk_i);
        stby <= 1'b0;
        wait_cyc(6);
        chk(standby, 1'b1);
        chk(bridge_on, 1'b0);
        chk(angle, 6'h08);
        chk(f_angle, 6'h08);
        close_out();
    end
endmodule
